// file: rtl/cbc_pkg.sv
// Constants and carrier types shared by the blanking and capture block.
//----------------------------------------------------------------------
// Overview of operation
// - Capture runs only while capture enable is set.
// - Rising filtered event latches time-base count.
// - One capture per reference interval, rest ignored.
// - Shadow mode copies capture at reference; reads shadow.
// - Active mode reads the captured value directly.
// - Active and shadow share one address.
// - Sixteen-bit offset delays window after reference.
// - Offset reloads from shadow at each reference.
// - Offset expiry starts or restarts the window.
// - Offset count readable, counts down, holds zero.
// - Offset counter never stops for debug halt.
// - Eight-bit width; zero gives no window.
// - Nonzero width loads window counter at expiry.
// - Window runs on across period boundaries.
// - Window count readable, counts down, holds zero.
// - Reference select: 00 period, 01 zero.
// - Blanking needs enable; invert flips window sense.
//----------------------------------------------------------------------
`default_nettype none

package cbc_pkg;

  //--------------------------------------------------------------------
  // Register byte offsets.
  //--------------------------------------------------------------------
  localparam int unsigned ADR_W = 5;
  localparam logic [4:0] OFS_FILTER_CTL   = 5'h00;
  localparam logic [4:0] OFS_CAPTURE_CTL  = 5'h04;
  localparam logic [4:0] OFS_CAPTURE_VAL  = 5'h08;
  localparam logic [4:0] OFS_BLANK_OFS    = 5'h0C;
  localparam logic [4:0] OFS_BLANK_OFSCNT = 5'h10;
  localparam logic [4:0] OFS_BLANK_WIDTH  = 5'h14;
  localparam logic [4:0] OFS_BLANK_WIDCNT = 5'h18;

  //--------------------------------------------------------------------
  // Field positions, encodings and reset values.
  //--------------------------------------------------------------------
  localparam int unsigned FC_BLANK_EN  = 2;
  localparam int unsigned FC_BLANK_INV = 3;
  localparam int unsigned FC_REF_LSB   = 4;
  localparam int unsigned CC_CAP_EN    = 0;
  localparam int unsigned CC_SHADOW    = 1;
  localparam logic [1:0]  REF_PERIOD   = 2'h0;
  localparam logic [1:0]  REF_ZERO     = 2'h1;
  localparam logic [15:0] RST_OFFSET   = 16'h0000;
  localparam logic [7:0]  RST_WIDTH    = 8'h00;
  localparam logic [15:0] RST_CAPTURE  = 16'h0000;

  //--------------------------------------------------------------------
  // Carrier types.
  //--------------------------------------------------------------------
  typedef struct packed {
    logic [15:0] count;
    logic        period_match;
    logic        zero_match;
  } cbc_tb_t;

  typedef struct packed {
    logic [1:0] ref_sel;
    logic       blank_inv;
    logic       blank_en;
    logic       shadow_sel;
    logic       cap_en;
  } cbc_ctrl_t;

  typedef struct packed {
    cbc_ctrl_t   ctrl;
    logic [15:0] offset_shadow;
    logic [7:0]  width;
    logic        ack;
    logic [31:0] rdata;
    logic        filt;
    logic        blank;
  } cbc_state_t;

  typedef struct packed {
    logic [15:0] active;
    logic [15:0] shadow;
    logic        locked;
    logic        evt_q;
  } cbc_cap_state_t;

endpackage

`default_nettype wire

// file: rtl/cbc_down_counter.sv
// Loadable down-counter that stops at zero and flags its expiry.
`default_nettype none

module cbc_down_counter
  import cbc_pkg::*;
#(
  parameter int unsigned W = 8
) (
  // Clock and reset.
  input  wire logic         clk_i,
  input  wire logic         rst_i,
  // Load request and value.
  input  wire logic         load_i,
  input  wire logic [W-1:0] load_val_i,
  // Present count and expiry strobe.
  output logic      [W-1:0] count_o,
  output logic              expire_o
);

  typedef struct packed {
    logic [W-1:0] count;
  } cbc_cnt_state_t;

  cbc_cnt_state_t st;
  cbc_cnt_state_t next_st;

  // A load wins over counting; a zero count holds until reloaded.
  always_comb begin
    next_st = st;
    if (load_i) begin
      next_st.count = load_val_i;
    end else if (st.count != '0) begin
      next_st.count = st.count - 1'b1;
    end
  end

  // Registers the counter state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Expiry is the step from one to zero, or a load of zero.
  assign count_o  = st.count;
  assign expire_o = load_i ? (load_val_i == '0) : (st.count == W'(1));

endmodule

`default_nettype wire

// file: rtl/cbc_capture.sv
// Time-base capture with one-shot lock and reference-point shadow.
`default_nettype none

module cbc_capture
  import cbc_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Control and events.
  input  wire logic        ref_i,
  input  wire logic        cap_en_i,
  input  wire logic        shadow_sel_i,
  input  wire logic        filt_i,
  input  wire logic [15:0] tb_count_i,
  // Captured values.
  output logic      [15:0] active_o,
  output logic      [15:0] shadow_o
);

  cbc_cap_state_t st;
  cbc_cap_state_t next_st;
  logic           take;

  // A capture in the reference cycle itself opens the new interval.
  assign take = cap_en_i && filt_i && !st.evt_q &&
                (!st.locked || ref_i);

  // Next state: shadow copy, lock release and capture.
  always_comb begin
    next_st       = st;
    next_st.evt_q = filt_i;
    if (ref_i) begin
      next_st.locked = 1'b0;
      if (!shadow_sel_i) begin
        next_st.shadow = st.active;
      end
    end
    if (take) begin
      next_st.active = tb_count_i;
      next_st.locked = 1'b1;
    end
  end

  // Registers the capture state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '{RST_CAPTURE, RST_CAPTURE, 1'b0, 1'b0};
    end else begin
      st <= next_st;
    end
  end

  assign active_o = st.active;
  assign shadow_o = st.shadow;

  //--------------------------------------------------------------------
  // Assertions.
  //--------------------------------------------------------------------
  property p_take;
    @(posedge clk_i) disable iff (rst_i)
    (cap_en_i && filt_i && !st.evt_q && !st.locked)
      |=> (st.active == $past(tb_count_i));
  endproperty
  a_take: assert property (p_take)
    else $error("capture missed a rising filtered event");

  property p_disabled;
    @(posedge clk_i) disable iff (rst_i)
    !cap_en_i |=> $stable(st.active);
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("capture changed while disabled");

  property p_locked;
    @(posedge clk_i) disable iff (rst_i)
    (st.locked && !ref_i) |=> $stable(st.active);
  endproperty
  a_locked: assert property (p_locked)
    else $error("second capture taken in one interval");

  property p_shadow_copy;
    @(posedge clk_i) disable iff (rst_i)
    (ref_i && !shadow_sel_i) |=> (st.shadow == $past(st.active));
  endproperty
  a_shadow_copy: assert property (p_shadow_copy)
    else $error("shadow not copied at reference point");

endmodule

`default_nettype wire

// file: rtl/cbc_blank_capture.sv
// Blanking window timer and capture block with a Wishbone register slave.
`default_nettype none

module cbc_blank_capture
  import cbc_pkg::*;
(
  // Clock and reset.
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  // Wishbone classic slave.
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  // Time base and compare event.
  input  wire cbc_tb_t          tb_i,
  input  wire logic             cmp_event_i,
  // Filtered event and blanking window.
  output logic                  filtered_event_o,
  output logic                  blank_window_o
);

  //--------------------------------------------------------------------
  // Declarations.
  //--------------------------------------------------------------------
  cbc_state_t  st;
  cbc_state_t  next_st;
  logic        req;
  logic        ref_pulse;
  logic        blank_now;
  logic        filt_now;
  logic        win_load;
  logic        off_expire;
  logic [15:0] off_cnt;
  logic [7:0]  win_cnt;
  logic [15:0] cap_active;
  logic [15:0] cap_shadow;
  logic [15:0] cap_read;
  logic [31:0] rd_mux;

  assign req = wb_cyc_i && wb_stb_i;

  //--------------------------------------------------------------------
  // Reference point and blanking window.
  //--------------------------------------------------------------------

  // Picks the reference pulse; reserved codes give no reference.
  always_comb begin
    unique case (st.ctrl.ref_sel)
      REF_PERIOD: ref_pulse = tb_i.period_match;
      REF_ZERO:   ref_pulse = tb_i.zero_match;
      default:    ref_pulse = 1'b0;
    endcase
  end

  // The window is the nonzero window count, gated and optionally
  // inverted; the inverted sense blanks everywhere outside it.
  assign blank_now = st.ctrl.blank_en &&
                     ((win_cnt != 8'h00) ^ st.ctrl.blank_inv);

  // Blanking masks the selected compare event.
  assign filt_now = cmp_event_i && !blank_now;

  // A zero width never loads the window counter.
  assign win_load = off_expire && (st.width != RST_WIDTH);

  // Offset counter: loaded from the shadow at every reference point.
  // It has no halt input, so debug stops never freeze it.
  cbc_down_counter #(
    .W          (16)
  ) u_offset (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .load_i     (ref_pulse),
    .load_val_i (st.offset_shadow),
    .count_o    (off_cnt),
    .expire_o   (off_expire)
  );

  // Window counter: loaded or restarted at each offset expiry with a nonzero width. No
  // reference pulse reaches it, so a window may span periods.
  cbc_down_counter #(
    .W          (8)
  ) u_window (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .load_i     (win_load),
    .load_val_i (st.width),
    .count_o    (win_cnt),
    .expire_o   ()
  );

  //--------------------------------------------------------------------
  // Counter capture.
  //--------------------------------------------------------------------

  // Capture watches the event after blanking.
  cbc_capture u_capture (
    .clk_i        (clk_i),
    .rst_i        (rst_i),
    .ref_i        (ref_pulse),
    .cap_en_i     (st.ctrl.cap_en),
    .shadow_sel_i (st.ctrl.shadow_sel),
    .filt_i       (filt_now),
    .tb_count_i   (tb_i.count),
    .active_o     (cap_active),
    .shadow_o     (cap_shadow)
  );

  // One address returns either copy, chosen by the shadow select.
  assign cap_read = st.ctrl.shadow_sel ? cap_active
                                       : cap_shadow;

  //--------------------------------------------------------------------
  // Register read multiplexer.
  //--------------------------------------------------------------------

  // Unused and reserved bits, and unmapped addresses, read as zero.
  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (wb_adr_i)
      OFS_FILTER_CTL: begin
        rd_mux[FC_BLANK_EN]        = st.ctrl.blank_en;
        rd_mux[FC_BLANK_INV]       = st.ctrl.blank_inv;
        rd_mux[FC_REF_LSB +: 2]    = st.ctrl.ref_sel;
      end
      OFS_CAPTURE_CTL: begin
        rd_mux[CC_CAP_EN]          = st.ctrl.cap_en;
        rd_mux[CC_SHADOW]          = st.ctrl.shadow_sel;
      end
      OFS_CAPTURE_VAL: begin
        rd_mux[15:0]               = cap_read;
      end
      OFS_BLANK_OFS: begin
        rd_mux[15:0]               = st.offset_shadow;
      end
      OFS_BLANK_OFSCNT: begin
        rd_mux[15:0]               = off_cnt;
      end
      OFS_BLANK_WIDTH: begin
        rd_mux[7:0]                = st.width;
      end
      OFS_BLANK_WIDCNT: begin
        rd_mux[7:0]                = win_cnt;
      end
      default: begin
        rd_mux = 32'h0000_0000;
      end
    endcase
  end

  //--------------------------------------------------------------------
  // Next state: bus handshake, register writes and outputs.
  //--------------------------------------------------------------------

  // Ack rises one cycle after a new request and lasts one cycle; a
  // write commits at the edge where the master sees ack high.
  always_comb begin
    next_st       = st;
    next_st.ack   = req && !st.ack;
    next_st.rdata = (req && !st.ack) ? rd_mux : 32'h0000_0000;
    next_st.filt  = filt_now;
    next_st.blank = blank_now;
    if (req && st.ack && wb_we_i) begin
      unique case (wb_adr_i)
        OFS_FILTER_CTL: begin
          if (wb_sel_i[0]) begin
            next_st.ctrl.blank_en  = wb_dat_i[FC_BLANK_EN];
            next_st.ctrl.blank_inv = wb_dat_i[FC_BLANK_INV];
            next_st.ctrl.ref_sel   = wb_dat_i[FC_REF_LSB +: 2];
          end
        end
        OFS_CAPTURE_CTL: begin
          if (wb_sel_i[0]) begin
            next_st.ctrl.cap_en     = wb_dat_i[CC_CAP_EN];
            next_st.ctrl.shadow_sel = wb_dat_i[CC_SHADOW];
          end
        end
        OFS_BLANK_OFS: begin
          // Software only reaches the shadow copy of the offset.
          if (wb_sel_i[0]) begin
            next_st.offset_shadow[7:0] = wb_dat_i[7:0];
          end
          if (wb_sel_i[1]) begin
            next_st.offset_shadow[15:8] = wb_dat_i[15:8];
          end
        end
        OFS_BLANK_WIDTH: begin
          if (wb_sel_i[0]) begin
            next_st.width = wb_dat_i[7:0];
          end
        end
        default: begin
          next_st.width = st.width;
        end
      endcase
    end
  end

  // Registers the block state.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st               <= '0;
      st.offset_shadow <= RST_OFFSET;
      st.width         <= RST_WIDTH;
    end else begin
      st <= next_st;
    end
  end

  //--------------------------------------------------------------------
  // Outputs.
  //--------------------------------------------------------------------
  assign wb_ack_o         = st.ack;
  assign wb_dat_o         = st.rdata;
  assign filtered_event_o = st.filt;
  assign blank_window_o   = st.blank;

  //--------------------------------------------------------------------
  // Assertions.
  //--------------------------------------------------------------------

  // A new bus request and a capture read.
  sequence s_new_req;
    req && !wb_ack_o;
  endsequence

  sequence s_cap_read;
    s_new_req ##0 (!wb_we_i && (wb_adr_i == OFS_CAPTURE_VAL));
  endsequence

  // Offset expiry with a nonzero width.
  sequence s_window_start;
    off_expire && (st.width != 8'h00);
  endsequence

  property p_ack_pulse;
    @(posedge clk_i) disable iff (rst_i)
    s_new_req |=> wb_ack_o ##1 !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse)
    else $error("bus ack not a single cycle after request");

  property p_cap_read;
    @(posedge clk_i) disable iff (rst_i)
    s_cap_read |=> (wb_dat_o[15:0] == ($past(st.ctrl.shadow_sel) ?
                   $past(cap_active) : $past(cap_shadow)));
  endproperty
  a_cap_read: assert property (p_cap_read)
    else $error("capture read returned the wrong copy");

  property p_ref_reserved;
    @(posedge clk_i) disable iff (rst_i)
    st.ctrl.ref_sel[1] |-> !ref_pulse;
  endproperty
  a_ref_reserved: assert property (p_ref_reserved)
    else $error("reserved reference code produced a reference");

  property p_offset_load;
    @(posedge clk_i) disable iff (rst_i)
    ref_pulse |=> (off_cnt == $past(st.offset_shadow));
  endproperty
  a_offset_load: assert property (p_offset_load)
    else $error("offset counter not loaded at reference");

  property p_offset_run;
    @(posedge clk_i) disable iff (rst_i)
    ((off_cnt != 16'h0000) && !ref_pulse)
      |=> (off_cnt == $past(off_cnt) - 16'h0001);
  endproperty
  a_offset_run: assert property (p_offset_run)
    else $error("offset counter did not count down");

  property p_offset_hold;
    @(posedge clk_i) disable iff (rst_i)
    ((off_cnt == 16'h0000) && !ref_pulse) |=> (off_cnt == 16'h0000);
  endproperty
  a_offset_hold: assert property (p_offset_hold)
    else $error("offset counter left zero without reload");

  property p_window_start;
    @(posedge clk_i) disable iff (rst_i)
    s_window_start |=> (win_cnt == $past(st.width));
  endproperty
  a_window_start: assert property (p_window_start)
    else $error("window counter not loaded at offset expiry");

  property p_zero_width;
    @(posedge clk_i) disable iff (rst_i)
    (off_expire && (st.width == 8'h00) && (win_cnt == 8'h00))
      |=> (win_cnt == 8'h00);
  endproperty
  a_zero_width: assert property (p_zero_width)
    else $error("zero width opened a window");

  property p_window_run;
    @(posedge clk_i) disable iff (rst_i)
    ((win_cnt > 8'h01) && !off_expire)
      |=> (win_cnt == $past(win_cnt) - 8'h01);
  endproperty
  a_window_run: assert property (p_window_run)
    else $error("window counter broke off or stalled");

  property p_suppress;
    @(posedge clk_i) disable iff (rst_i)
    blank_now |=> !filtered_event_o;
  endproperty
  a_suppress: assert property (p_suppress)
    else $error("event passed during blanking");

  property p_blank_off;
    @(posedge clk_i) disable iff (rst_i)
    !st.ctrl.blank_en |=> !blank_window_o;
  endproperty
  a_blank_off: assert property (p_blank_off)
    else $error("blanking shown while disabled");

endmodule

`default_nettype wire

// file: dv/tb_top.sv
// Self-checking random bench for the blanking and capture block.
`default_nettype none

module tb_top
  import cbc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  //--------------------------------------------------------------------
  // Stimulus, outputs and reference state.
  //--------------------------------------------------------------------
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        wb_cyc_i, wb_stb_i, wb_we_i;
  logic [4:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        wb_ack_o, cmp_event_i, filtered_event_o, blank_window_o;
  cbc_tb_t     tb_i;
  logic [1:0]  m_sel, m_cc;
  logic        m_en, m_inv, m_lock, m_evq, e_filt, e_blank, kick, run;
  logic [15:0] m_ofs, m_ocnt, m_act, m_shd;
  logic [7:0]  m_wid, m_wcnt;
  logic [15:0] ofs_tab [4] = '{16'h0000, 16'h0001, 16'h0004, 16'h0100};
  int          error_cnt = 0;
  int          total_checks = 0;

  // Free-running 250 MHz clock.
  always #2 clk_i = ~clk_i;

  cbc_blank_capture u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .tb_i(tb_i), .cmp_event_i(cmp_event_i),
    .filtered_event_o(filtered_event_o), .blank_window_o(blank_window_o)
  );

  // Time base counts up; reference pulses and events arrive at random.
  always @(posedge clk_i) begin
    tb_i.count        <= tb_i.count + 16'h0001;
    tb_i.period_match <= kick || (run && $urandom_range(36) == 0);
    tb_i.zero_match   <= run && $urandom_range(40) == 0;
    cmp_event_i       <= run && $urandom_range(2) == 0;
    kick              <= 1'b0;
  end

  // Cycle model of counters, window, masking and capture.
  always @(posedge clk_i) begin : model
    logic refp, expv, blk, evt, cap;
    if (rst_i) begin
      {m_ocnt, m_wcnt, m_act, m_shd} = '0;
      {m_lock, m_evq, e_filt, e_blank} = '0;
    end else begin
      refp = (m_sel == REF_PERIOD && tb_i.period_match)
          || (m_sel == REF_ZERO && tb_i.zero_match);
      blk = m_en & ((m_wcnt != 8'h00) ^ m_inv);
      evt = cmp_event_i & !blk;
      cap = m_cc[CC_CAP_EN] && evt && !m_evq && (!m_lock || refp);
      e_filt = evt;
      e_blank = blk;
      m_evq = evt;
      if (refp) begin
        if (!m_cc[CC_SHADOW]) m_shd = m_act;
        m_lock = 1'b0;
      end
      if (cap) begin
        m_act = tb_i.count;
        m_lock = 1'b1;
      end
      expv = 1'b0;
      if (refp) begin
        m_ocnt = m_ofs;
        expv = (m_ofs == 16'h0000);
      end else if (m_ocnt != 16'h0000) begin
        expv = (m_ocnt == 16'h0001);
        m_ocnt = m_ocnt - 16'h0001;
      end
      if (expv && m_wid != 8'h00) m_wcnt = m_wid;
      else if (m_wcnt != 8'h00) m_wcnt = m_wcnt - 8'h01;
    end
  end

  //--------------------------------------------------------------------
  // Checking and bus tasks.
  //--------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // The filtered event and blanking window outputs are compared with the model every cycle.
  always @(negedge clk_i) begin
    if (!rst_i) begin
      chk("filtered_event_o", {31'h0, e_filt}, {31'h0, filtered_event_o});
      chk("blank_window_o", {31'h0, e_blank}, {31'h0, blank_window_o});
    end
  end

  // Register value the model predicts at a given address.
  function automatic logic [31:0] exp_reg(input logic [4:0] a);
    case (a)
      OFS_FILTER_CTL:   return {26'h0, m_sel, m_inv, m_en, 2'b00};
      OFS_CAPTURE_CTL:  return {30'h0, m_cc};
      OFS_CAPTURE_VAL:  return {16'h0, m_cc[CC_SHADOW] ? m_act : m_shd};
      OFS_BLANK_OFS:    return {16'h0, m_ofs};
      OFS_BLANK_OFSCNT: return {16'h0, m_ocnt};
      OFS_BLANK_WIDTH:  return {24'h0, m_wid};
      OFS_BLANK_WIDCNT: return {24'h0, m_wcnt};
      default:          return 32'h0000_0000;
    endcase
  endfunction

  function automatic logic [4:0] rnd_adr();
    return {3'($urandom), 2'b00};
  endfunction

  // One classic cycle; entered just after a rising edge.
  task automatic wb_xfer(input logic w, input logic [4:0] a,
                         input logic [31:0] d, input logic [3:0] s);
    logic [31:0] e;
    int          n;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_sel_i <= s;
    wb_dat_i <= d;
    @(negedge clk_i);
    e = exp_reg(a);
    n = 0;
    while (wb_ack_o !== 1'b1 && n < 50) begin
      @(negedge clk_i);
      n++;
    end
    chk("ack_delay", 32'h1, n);
    if (!w) chk("wb_dat_o", e, wb_dat_o);
    @(posedge clk_i);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (w && s[0]) begin
      case (a)
        OFS_FILTER_CTL:  {m_sel, m_inv, m_en} <= d[5:2];
        OFS_CAPTURE_CTL: m_cc <= d[1:0];
        OFS_BLANK_OFS:   m_ofs[7:0] <= d[7:0];
        OFS_BLANK_WIDTH: m_wid <= d[7:0];
        default:         ;
      endcase
    end
    if (w && s[1] && a == OFS_BLANK_OFS) m_ofs[15:8] <= d[15:8];
    @(posedge clk_i);
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  //--------------------------------------------------------------------
  // Test sequence.
  //--------------------------------------------------------------------
  initial begin
    logic [4:0]  a;
    logic [31:0] d;
    void'($urandom(32'hEEAA));
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} = '0;
    {tb_i, cmp_event_i, kick, run} = '0;
    {m_sel, m_cc, m_en, m_inv, m_ofs, m_wid} = '0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    for (int i = 0; i < 8; i++) begin
      wb_xfer(1'b0, 5'(i * 4), 32'h0, 4'hF);
    end
    $display("test reset_values done");
    // Random writes, read-only and unmapped places included.
    for (int i = 0; i < 60; i++) begin
      wb_xfer(1'b1, rnd_adr(), $urandom, 4'($urandom));
      wb_xfer(1'b0, rnd_adr(), 32'h0, 4'hF);
    end
    $display("test register_access done");
    // Reference pulses at growing spacing hit reload, expiry and restart.
    for (int v = 0; v < 2; v++) begin
      wb_xfer(1'b1, OFS_FILTER_CTL, v ? 32'h0C : 32'h04, 4'h1);
      wb_xfer(1'b1, OFS_CAPTURE_CTL, 32'h0, 4'h1);
      wb_xfer(1'b1, OFS_BLANK_WIDTH, 32'h06, 4'h1);
      foreach (ofs_tab[k]) begin
        wb_xfer(1'b1, OFS_BLANK_OFS, {16'h0, ofs_tab[k]}, 4'h3);
        for (int g = 1; g <= 9; g++) begin
          @(negedge clk_i);
          kick = 1'b1;
          repeat (g) @(posedge clk_i);
        end
        wb_xfer(1'b0, OFS_BLANK_OFSCNT, 32'h0, 4'hF);
        wb_xfer(1'b0, OFS_BLANK_WIDCNT, 32'h0, 4'hF);
        repeat (300) @(posedge clk_i);
        wb_xfer(1'b0, OFS_BLANK_OFSCNT, 32'h0, 4'hF);
      end
    end
    $display("test blanking_directed done");
    // Random bus traffic against a live time base.
    run <= 1'b1;
    for (int i = 0; i < 500; i++) begin
      a = rnd_adr();
      d = $urandom;
      if (a == OFS_BLANK_OFS) d = $urandom_range(300);
      wb_xfer(1'($urandom), a, d, 4'($urandom));
    end
    run <= 1'b0;
    repeat (4) @(posedge clk_i);
    $display("test random_traffic done");
    stop_test();
  end

  // Watchdog against a hung handshake.
  initial begin
    repeat (20000) @(posedge clk_i);
    error_cnt++;
    stop_test();
  end

endmodule

`default_nettype wire
